// ### hw/oma_regs.svh
/*
 * Register offsets, reset values and sizes of the output macrocell array.
 * Assumes a 32-bit Avalon-MM slave with byte addresses on an 8-bit bus.
 */
`ifndef OMA_REGS_SVH
`define OMA_REGS_SVH

// ****************************************************************
// Array size.
// ****************************************************************
`define OMA_N_CELLS 10
`define OMA_N_TERMS 120
`define OMA_MIN_TERMS 8
`define OMA_TERM_STEP 2

// ****************************************************************
// Register map.
// ****************************************************************
`define OMA_REG_POLARITY 8'h00
`define OMA_REG_MODE 8'h04
`define OMA_REG_OE_SEL 8'h08
`define OMA_REG_Q_STATE 8'h0c
`define OMA_REG_PIN_STATE 8'h10
`define OMA_FB_LSB 16
`define OMA_POLARITY_RST 10'h3ff
`define OMA_MODE_RST 10'h000
`define OMA_OE_SEL_RST 20'h0_0000
`define OMA_RDATA_ZERO 32'h0000_0000

`endif

// ### hw/oma_pkg.sv
/*
 * Types shared by the output macrocell array files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package oma_pkg;

	// Output enable source of a combinatorial cell.
	typedef enum logic [1:0] {OMA_OE_OFF, OMA_OE_ON, OMA_OE_TERM} oma_oe_sel_t;

	// Per-cell configuration.
	typedef struct packed {
		logic registered;
		logic active_high;
		oma_oe_sel_t oe_sel;
	} oma_cell_cfg_t;

	// One Avalon-MM request as seen by the slave.
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} oma_avmm_req_t;

endpackage

// ### hw/oma_macrocell.sv
/*
 * One output macrocell: sum term, D flip-flop, polarity, enable, feedback.
 * Assumes the clear input already merges the device reset and zeroing term.
 */
`timescale 1ns/1ps

module oma_macrocell #(
	parameter int N_TERMS = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_clr_n,
	input wire logic [N_TERMS-1:0] i_terms,
	input wire logic i_oe_term,
	input wire logic i_sync_preset_term,
	input wire oma_pkg::oma_cell_cfg_t i_cfg,
	input wire logic i_pin_in,
	output logic o_pin_out,
	output logic o_pin_oe_n,
	output logic o_fb_true,
	output logic o_fb_comp,
	output logic o_q,
	output logic o_sum
);

	logic q_r;
	logic q_nxt;
	logic sum;

	// Sum term and the flip-flop's next state; preset wins over logic.
	always_comb begin
		sum = |i_terms;
		q_nxt = i_sync_preset_term ? 1'b1 : sum;
	end

	// Zeroing clears Q at once, with no clock needed.
	always_ff @(posedge i_ref_clk or negedge i_clr_n) begin
		if (!i_clr_n) begin
			q_r <= 1'b0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// Pin path, enable and feedback; polarity acts after Q.
	always_comb begin
		o_q = q_r;
		o_sum = sum;
		if (i_cfg.registered) begin
			o_pin_out = q_r ^ ~i_cfg.active_high;
			o_pin_oe_n = ~i_oe_term;
			o_fb_true = ~q_r;
			o_fb_comp = q_r;
		end else begin
			o_pin_out = sum ^ ~i_cfg.active_high;
			case (i_cfg.oe_sel)
				oma_pkg::OMA_OE_ON: o_pin_oe_n = 1'b0;
				oma_pkg::OMA_OE_TERM: o_pin_oe_n = ~i_oe_term;
				default: o_pin_oe_n = 1'b1;
			endcase
			o_fb_true = i_pin_in;
			o_fb_comp = ~i_pin_in;
		end
	end

endmodule

// ### hw/oma_avmm_handshake.sv
/*
 * Avalon-MM waitrequest handshake: every access is answered one cycle later.
 * Assumes the master holds its request until it sees waitrequest low.
 */
`timescale 1ns/1ps
`include "oma_regs.svh"

module oma_avmm_handshake (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire oma_pkg::oma_avmm_req_t i_req,
	input wire logic [31:0] i_rdata,
	output logic o_waitrequest,
	output logic [31:0] o_readdata,
	output logic o_commit
);

	logic wait_r;
	logic wait_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	// Drop waitrequest for exactly one cycle per request; reads capture data first.
	always_comb begin
		wait_nxt = ~((i_req.read | i_req.write) & wait_r);
		rdata_nxt = (i_req.read & wait_r) ? i_rdata : rdata_r;
		o_commit = (i_req.read | i_req.write) & ~wait_r;
	end

	// Waitrequest idles high so nothing completes by accident.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_r <= 1'b1;
			rdata_r <= `OMA_RDATA_ZERO;
		end else begin
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_waitrequest = wait_r;
	assign o_readdata = rdata_r;

endmodule

// ### hw/oma_output_macrocell_array.sv
/*
 * Ten output macrocells with shared zeroing and preset terms, configured
 * over Avalon-MM. Assumes an external AND array supplies product terms,
 * and that i_pins carries the resolved level of each pin.
 */
`timescale 1ns/1ps
`include "oma_regs.svh"

module oma_output_macrocell_array (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [`OMA_N_TERMS-1:0] i_product_terms,
	input wire logic [`OMA_N_CELLS-1:0] i_oe_terms,
	input wire logic i_async_zeroing_term,
	input wire logic i_sync_preset_term,
	input wire logic [`OMA_N_CELLS-1:0] i_pins,
	output logic [`OMA_N_CELLS-1:0] o_pins,
	output logic [`OMA_N_CELLS-1:0] o_pins_oe_n,
	output logic [`OMA_N_CELLS-1:0] o_fb_true,
	output logic [`OMA_N_CELLS-1:0] o_fb_comp
);

	// ****************************************************************
	// Helper functions.
	// ****************************************************************

	// Product terms of cell k: outer pair gets fewest, inner pair most.
	function automatic int term_count(input int k);
		int d;
		d = (k < `OMA_N_CELLS / 2) ? k : `OMA_N_CELLS - 1 - k;
		return `OMA_MIN_TERMS + `OMA_TERM_STEP * d;
	endfunction

	// First bit of cell k within the flat product-term bus.
	function automatic int term_base(input int k);
		int s;
		s = 0;
		for (int j = 0; j < k; j++) begin
			s = s + term_count(j);
		end
		return s;
	endfunction

	// Byte-lane merge of a write into an old register word.
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0] be
	);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************************************
	// Bus request and handshake.
	// ****************************************************************

	oma_pkg::oma_avmm_req_t req;
	logic [31:0] rdata;
	logic commit;
	logic wr_commit;

	// Gather the Avalon signals into one request word.
	always_comb begin
		req.read = i_avs_read;
		req.write = i_avs_write;
		req.address = i_avs_address;
		req.writedata = i_avs_writedata;
		req.byteenable = i_avs_byteenable;
	end

	oma_avmm_handshake u_bus (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_req(req),
		.i_rdata(rdata),
		.o_waitrequest(o_avs_waitrequest),
		.o_readdata(o_avs_readdata),
		.o_commit(commit)
	);

	assign wr_commit = commit & req.write;

	// ****************************************************************
	// Configuration registers.
	// ****************************************************************

	logic [`OMA_N_CELLS-1:0] polarity_r;
	logic [`OMA_N_CELLS-1:0] polarity_nxt;
	logic [`OMA_N_CELLS-1:0] mode_r;
	logic [`OMA_N_CELLS-1:0] mode_nxt;
	logic [2*`OMA_N_CELLS-1:0] oe_sel_r;
	logic [2*`OMA_N_CELLS-1:0] oe_sel_nxt;
	logic [31:0] pol_word;
	logic [31:0] mode_word;
	logic [31:0] oe_word;

	// Merge the write into all three words; only the addressed one is kept.
	always_comb begin
		pol_word = lane_merge(32'(polarity_r), req.writedata, req.byteenable);
		mode_word = lane_merge(32'(mode_r), req.writedata, req.byteenable);
		oe_word = lane_merge(32'(oe_sel_r), req.writedata, req.byteenable);
	end

	// A write lands only at the edge where waitrequest is low.
	always_comb begin
		polarity_nxt = polarity_r;
		mode_nxt = mode_r;
		oe_sel_nxt = oe_sel_r;
		if (wr_commit) begin
			case (req.address)
				`OMA_REG_POLARITY: begin
					polarity_nxt = pol_word[`OMA_N_CELLS-1:0];
				end
				`OMA_REG_MODE: begin
					mode_nxt = mode_word[`OMA_N_CELLS-1:0];
				end
				`OMA_REG_OE_SEL: begin
					oe_sel_nxt = oe_word[2*`OMA_N_CELLS-1:0];
				end
				default: begin
					polarity_nxt = polarity_r;
				end
			endcase
		end
	end

	// Reset leaves every cell combinatorial, active high and not driving.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			polarity_r <= `OMA_POLARITY_RST;
			mode_r <= `OMA_MODE_RST;
			oe_sel_r <= `OMA_OE_SEL_RST;
		end else begin
			polarity_r <= polarity_nxt;
			mode_r <= mode_nxt;
			oe_sel_r <= oe_sel_nxt;
		end
	end

	// ****************************************************************
	// Macrocells.
	// ****************************************************************

	oma_pkg::oma_cell_cfg_t cfg [`OMA_N_CELLS];
	logic [`OMA_N_CELLS-1:0] q;
	logic [`OMA_N_CELLS-1:0] sum;
	logic clr_n;

	// The zeroing term shares the flip-flops' asynchronous clear.
	assign clr_n = i_rst_n & ~i_async_zeroing_term;

	// Spread the configuration fields into one struct per cell.
	always_comb begin
		for (int k = 0; k < `OMA_N_CELLS; k++) begin
			cfg[k].registered = mode_r[k];
			cfg[k].active_high = polarity_r[k];
			cfg[k].oe_sel = oma_pkg::oma_oe_sel_t'(oe_sel_r[2*k +: 2]);
		end
	end

	// Each cell takes its own slice of terms; preset is shared.
	for (genvar k = 0; k < `OMA_N_CELLS; k++) begin : g_cell
		localparam int W = term_count(k);
		localparam int B = term_base(k);
		oma_macrocell #(
			.N_TERMS(W)
		) u_cell (
			.i_ref_clk(i_ref_clk),
			.i_clr_n(clr_n),
			.i_terms(i_product_terms[B +: W]),
			.i_oe_term(i_oe_terms[k]),
			.i_sync_preset_term(i_sync_preset_term),
			.i_cfg(cfg[k]),
			.i_pin_in(i_pins[k]),
			.o_pin_out(o_pins[k]),
			.o_pin_oe_n(o_pins_oe_n[k]),
			.o_fb_true(o_fb_true[k]),
			.o_fb_comp(o_fb_comp[k]),
			.o_q(q[k]),
			.o_sum(sum[k])
		);
	end

	// ****************************************************************
	// Read-back.
	// ****************************************************************

	// Status words show live Q state, pin levels and feedback.
	always_comb begin
		rdata = `OMA_RDATA_ZERO;
		case (req.address)
			`OMA_REG_POLARITY: rdata[`OMA_N_CELLS-1:0] = polarity_r;
			`OMA_REG_MODE: rdata[`OMA_N_CELLS-1:0] = mode_r;
			`OMA_REG_OE_SEL: rdata[2*`OMA_N_CELLS-1:0] = oe_sel_r;
			`OMA_REG_Q_STATE: rdata[`OMA_N_CELLS-1:0] = q;
			`OMA_REG_PIN_STATE: begin
				rdata[`OMA_N_CELLS-1:0] = i_pins;
				rdata[`OMA_FB_LSB +: `OMA_N_CELLS] = o_fb_true;
			end
			default: rdata = `OMA_RDATA_ZERO;
		endcase
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	localparam logic [`OMA_N_CELLS-1:0] ALL_ONES = '1;

	// Pin, enable and feedback checks split by mode; Q checks and the o_fb_comp check cover every cell.
	logic [`OMA_N_CELLS-1:0] comb_on;
	logic [`OMA_N_CELLS-1:0] comb_off;
	logic [`OMA_N_CELLS-1:0] comb_term;
	always_comb begin
		for (int k = 0; k < `OMA_N_CELLS; k++) begin
			comb_on[k] = ~mode_r[k] & (cfg[k].oe_sel == oma_pkg::OMA_OE_ON);
			comb_off[k] = ~mode_r[k] & (cfg[k].oe_sel == oma_pkg::OMA_OE_OFF);
			comb_term[k] = ~mode_r[k] & (cfg[k].oe_sel == oma_pkg::OMA_OE_TERM);
		end
	end

	a_zero_clears_q: assert property (i_async_zeroing_term |-> q == '0)
		else $error("zeroing term did not clear the flip-flops");

	a_preset_loads_ones: assert property (
		(i_sync_preset_term && !i_async_zeroing_term) ##1 !i_async_zeroing_term
		|-> q == ALL_ONES)
		else $error("preset term did not load ones at the next edge");

	a_q_follows_sum: assert property (
		(!i_sync_preset_term && !i_async_zeroing_term) ##1 !i_async_zeroing_term
		|-> q == $past(sum))
		else $error("flip-flops did not capture the sum terms");

	a_reg_pin_polarity: assert property (
		((o_pins ^ q ^ ~polarity_r) & mode_r) == '0)
		else $error("registered pin does not follow Q through polarity");

	a_comb_pin_direct: assert property (
		((o_pins ^ sum ^ ~polarity_r) & ~mode_r) == '0)
		else $error("combinatorial pin does not follow its sum term");

	a_reg_oe_term: assert property (
		((~o_pins_oe_n ^ i_oe_terms) & mode_r) == '0)
		else $error("registered enable does not follow its product term");

	a_comb_oe_fixed: assert property (
		((o_pins_oe_n & comb_on) == '0) && ((~o_pins_oe_n & comb_off) == '0))
		else $error("fixed combinatorial enable is wrong");

	a_reg_feedback_q: assert property (
		((o_fb_true ^ ~q) & mode_r) == '0 && ((o_fb_comp ^ q) & mode_r) == '0)
		else $error("registered feedback is not from inverted Q");

	a_comb_feedback_pin: assert property (
		((o_fb_true ^ i_pins) & ~mode_r) == '0 && (o_fb_true ^ o_fb_comp) == ALL_ONES)
		else $error("combinatorial feedback is not the pin level");

	a_reset_polarity_q: assert property (
		$fell(i_async_zeroing_term) |-> ((o_pins ^ ~polarity_r) & mode_r) == '0)
		else $error("cleared register does not show through polarity");

	a_bus_answer_next: assert property (
		((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
		else $error("bus request not answered in one cycle");

	a_mode_write_lands: assert property (
		(wr_commit && req.address == `OMA_REG_MODE && req.byteenable == 4'hf)
		|=> mode_r == $past(req.writedata[`OMA_N_CELLS-1:0]))
		else $error("mode register did not take the written value");

	a_clear_pin_polarity: assert property (
		i_async_zeroing_term |-> ((o_pins ^ ~polarity_r) & mode_r) == '0)
		else $error("cleared registered pin does not follow polarity");

	a_preset_pin_level: assert property (
		(i_sync_preset_term && !i_async_zeroing_term) ##1 !i_async_zeroing_term
		|-> ((o_pins ^ polarity_r) & mode_r) == '0)
		else $error("preset registered pin does not follow polarity");

	a_wait_idle_high: assert property (
		!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
		else $error("waitrequest low without a request");

	a_wait_one_cycle: assert property (
		!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	a_read_data_taken: assert property (
		(i_avs_read && o_avs_waitrequest) |=> o_avs_readdata == $past(rdata))
		else $error("read data not captured when the read was taken");

	a_pol_write_lands: assert property (
		(wr_commit && req.address == `OMA_REG_POLARITY && req.byteenable == 4'hf)
		|=> polarity_r == $past(req.writedata[`OMA_N_CELLS-1:0]))
		else $error("polarity register did not take the written value");

	a_oe_write_lands: assert property (
		(wr_commit && req.address == `OMA_REG_OE_SEL && req.byteenable == 4'hf)
		|=> oe_sel_r == $past(req.writedata[2*`OMA_N_CELLS-1:0]))
		else $error("enable select register did not take the written value");

	a_comb_oe_term: assert property (
		((o_pins_oe_n ^ ~i_oe_terms) & comb_term) == '0)
		else $error("term-driven combinatorial enable is wrong");

	a_clear_keeps_config: assert property (
		(i_async_zeroing_term && !wr_commit) |=> mode_r == $past(mode_r))
		else $error("zeroing term disturbed the mode register");

endmodule

// ### verif/oma_board.sv
/*
 * Board-side partner of the macrocell array pins.
 * Assumes pull-ups on every pin and that board drivers back off where the device drives.
 */
`timescale 1ns/1ps

module oma_board (
	input wire logic [9:0] i_pins_out,
	input wire logic [9:0] i_pins_oe_n,
	input wire logic [9:0] i_drive_en,
	input wire logic [9:0] i_drive_val,
	output logic [9:0] o_pins
);
	// ****************************************************************
	// Wire resolution.
	// ****************************************************************
	// An undriven pin floats to its pull-up, never to the last level seen.
	assign o_pins = (~i_pins_oe_n & i_pins_out) |
		(i_pins_oe_n & ((i_drive_en & i_drive_val) | ~i_drive_en));
endmodule

// ### verif/oma_output_macrocell_array_bench.sv
/*
 * Self-checking bench of the output macrocell array.
 * Assumes the register map of oma_regs.svh and a one-cycle bus answer.
 */
`timescale 1ns/1ps
`include "oma_regs.svh"

module oma_output_macrocell_array_bench;
	logic i_ref_clk, i_rst_n, rd, wr, wreq, az, sp, pin_req;
	logic [7:0] addr;
	logic [31:0] wd, rdata, x;
	logic [3:0] be;
	logic [119:0] pt, tpt;
	logic [9:0] oet, pins, opins, oen, fbt, fbc, den, dval, pol, s, res;
	logic [19:0] y;
	logic [31:0] rq[$];
	logic [19:0] pq[$];
	int mismatches, n_checks, cyc;
	int cnt[10] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};

	oma_output_macrocell_array dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
		.i_product_terms(pt), .i_oe_terms(oet), .i_async_zeroing_term(az),
		.i_sync_preset_term(sp), .i_pins(pins), .o_pins(opins), .o_pins_oe_n(oen),
		.o_fb_true(fbt), .o_fb_comp(fbc));
	oma_board board_u (.i_pins_out(opins), .i_pins_oe_n(oen), .i_drive_en(den),
		.i_drive_val(dval), .o_pins(pins));

	// ****************************************************************
	// Helpers.
	// ****************************************************************
	// Sum term of each cell over its own slice of the term vector.
	function automatic logic [9:0] sums(input logic [119:0] p);
		int b;
		logic [9:0] r;
		b = 0;
		r = '0;
		for (int k = 0; k < 10; k++) begin
			for (int i = 0; i < cnt[k]; i++) r[k] = r[k] | p[b + i];
			b += cnt[k];
		end
		return r;
	endfunction

	function automatic logic [119:0] rpt();
		return 120'({$urandom, $urandom, $urandom, $urandom});
	endfunction

	// Holds the request until waitrequest is sampled low, then releases it.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] e);
		@(posedge i_ref_clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wd <= d;
		be <= e;
		do @(posedge i_ref_clk); while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
	endtask

	// Pin values only matter where the cell drives its pin.
	task automatic pchk(input logic [9:0] oe, input logic [9:0] p);
		@(posedge i_ref_clk);
		pq.push_back({oe, p & ~oe});
		pin_req <= 1'b1;
		@(posedge i_ref_clk);
		pin_req <= 1'b0;
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ****************************************************************
	// Clock, watchdog and result monitor.
	// ****************************************************************
	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end

	// The oldest note is taken whenever a read answer or a pin snapshot appears.
	always @(posedge i_ref_clk) begin
		cyc++;
		if (rd && wreq === 1'b0) begin
			x = rq.pop_front();
			n_checks++;
			if (rdata !== x) begin
				mismatches++;
				$display("ERROR readdata exp %h got %h", x, rdata);
			end
		end
		if (pin_req) begin
			y = pq.pop_front();
			n_checks += 2;
			if ({oen, opins & ~oen} !== y || fbc !== ~fbt) begin
				mismatches++;
				$display("ERROR pins exp %h got %h", y, {oen, opins & ~oen});
			end
		end
		// The limit is checked last so nothing runs after the closing report.
		if (cyc == 5000) begin
			mismatches++;
			$display("ERROR timeout exp %0d got %0d", 4999, cyc);
			finish_test;
		end
	end

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	initial begin
		{i_rst_n, rd, wr, az, sp, pin_req, addr, wd, be, pt, oet, den, dval} = '0;
		void'($urandom(93));
		repeat (6) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		rchk(`OMA_REG_POLARITY, 32'h0000_03ff);
		rchk(`OMA_REG_MODE, 32'h0000_0000);
		rchk(`OMA_REG_OE_SEL, 32'h0000_0000);
		rchk(8'h20, 32'h0000_0000);
		pchk(10'h3ff, 10'h000);
		// A single term walks across the array and must light its owner only.
		wreg(`OMA_REG_OE_SEL, 32'h0005_5555);
		for (int i = 0; i < 120; i++) begin
			pt <= 120'h1 << i;
			pchk(10'h000, sums(120'h1 << i));
		end
		for (int n = 0; n < 4; n++) begin
			pol = 10'($urandom);
			wreg(`OMA_REG_POLARITY, {22'h0, pol});
			wreg(`OMA_REG_OE_SEL, 32'h000a_aaaa);
			tpt = rpt();
			s = 10'($urandom);
			pt <= tpt;
			oet <= s;
			pchk(~s, sums(tpt) ^ ~pol);
			wreg(`OMA_REG_OE_SEL, n[0] ? 32'h000f_ffff : 32'h0000_0000);
			den <= 10'($urandom);
			dval <= 10'($urandom);
			pchk(10'h3ff, 10'h000);
			res = (den & dval) | ~den;
			rchk(`OMA_REG_PIN_STATE, {6'h0, res, 6'h0, res});
		end
		// Registered cells: pin from Q, enable from the cell's own term.
		wreg(`OMA_REG_MODE, 32'h0000_03ff);
		for (int n = 0; n < 3; n++) begin
			pol = 10'($urandom);
			wreg(`OMA_REG_POLARITY, {22'h0, pol});
			pt <= rpt();
			oet <= 10'($urandom);
			@(posedge i_ref_clk);
			den <= ~oet;
			dval <= 10'($urandom);
			s = sums(pt);
			pchk(~oet, s ^ ~pol);
			rchk(`OMA_REG_Q_STATE, {22'h0, s});
			res = (oet & (s ^ ~pol)) | (~oet & dval);
			rchk(`OMA_REG_PIN_STATE, {6'h0, ~s, 6'h0, res});
		end
		pt <= '0;
		sp <= 1'b1;
		pchk(~oet, pol);
		rchk(`OMA_REG_Q_STATE, 32'h0000_03ff);
		pt <= '1;
		az <= 1'b1;
		pchk(~oet, ~pol);
		rchk(`OMA_REG_Q_STATE, 32'h0000_0000);
		rchk(`OMA_REG_MODE, 32'h0000_03ff);
		az <= 1'b0;
		sp <= 1'b0;
		pt <= '0;
		rchk(`OMA_REG_Q_STATE, 32'h0000_0000);
		// Lane merge, read-only ignore and a reset in mid-run.
		bus(1'b1, `OMA_REG_POLARITY, 32'h0000_0000, 4'b0001);
		rchk(`OMA_REG_POLARITY, {22'h0, pol & 10'h300});
		wreg(`OMA_REG_Q_STATE, 32'hffff_ffff);
		rchk(`OMA_REG_Q_STATE, 32'h0000_0000);
		i_rst_n <= 1'b0;
		@(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		rchk(`OMA_REG_MODE, 32'h0000_0000);
		finish_test;
	end
endmodule
